//--- hw/byte_timeout_timer.sv
// General-purpose timeout timer with byte-timeout mode, registers on a plain port.
// Assumes a single clock, synchronous inputs and a one-cycle pulse per FIFO byte.
`timescale 1ns/1ps
module byte_timeout_timer #(
	parameter int unsigned TICK_CYCLES = byte_timer_pkg::TICK_CYCLES,
	parameter int unsigned TICK_SHIFT = 0,
	parameter longint unsigned TICKS_300 = byte_timer_pkg::TICKS_300S,
	parameter longint unsigned TICKS_1000 = byte_timer_pkg::TICKS_1000S
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic fifo_byte_i,
	output logic [7:0] rdata_o,
	output logic irq_o,
	output logic running_o
);
	localparam int unsigned TW = byte_timer_pkg::TICK_W;
	localparam int unsigned SW = byte_timer_pkg::STAT_W;

	if (TICK_SHIFT > 30) begin : g_chk
		$error("byte_timeout_timer: TICK_SHIFT above the largest exponent");
	end

	// State of the block in one record; the prescaler count stays in u_prescale
	typedef struct packed {
		logic [3:0] code_low;
		logic [1:0] code_high;
		logic byte_mode;
		logic periodic;
		logic start;
		byte_timer_pkg::timer_state_t state;
		logic [TW-1:0] ticks;
		logic [TW-1:0] snap;
		logic [7:0] expiries;
		logic [SW-1:0] status;
		logic [SW-1:0] mask;
		logic [7:0] rdata;
		logic irq;
		logic running;
	} tmr_state_t;

	localparam tmr_state_t RESET_VAL = '{
		code_low: byte_timer_pkg::DUR_LOW_RESET[3:0],
		code_high: byte_timer_pkg::DUR_HIGH_RESET[1:0],
		byte_mode: byte_timer_pkg::CTRL_RESET[byte_timer_pkg::CTRL_BYTE_MODE],
		periodic: byte_timer_pkg::CTRL_RESET[byte_timer_pkg::CTRL_PERIODIC],
		start: 1'b0,
		state: byte_timer_pkg::ST_IDLE,
		ticks: '0,
		snap: '0,
		expiries: 8'h00,
		status: byte_timer_pkg::STAT_RESET,
		mask: byte_timer_pkg::MASK_RESET,
		rdata: 8'h00,
		irq: 1'b0,
		running: 1'b0
	};

	tmr_state_t s_r;
	tmr_state_t s_nxt;

	logic [TW-1:0] limit;
	logic enabled;
	logic restart;
	logic tick;
	logic last_tick;
	logic [SW-1:0] events;

	// Picks one byte of the wide elapsed snapshot
	function automatic logic [7:0] snap_byte(input logic [TW-1:0] v, input logic [7:0] idx);
		logic [8*byte_timer_pkg::ELAPSED_BYTES-1:0] w;
		w = (8*byte_timer_pkg::ELAPSED_BYTES)'(v);
		snap_byte = w[idx[2:0]*8 +: 8];
	endfunction : snap_byte

	// Table lookup of the programmed code
	duration_decode #(
		.SHIFT(TICK_SHIFT),
		.TICKS_300(TICKS_300),
		.TICKS_1000(TICKS_1000)
	) u_decode (
		.code_i({s_r.code_high, s_r.code_low}),
		.limit_o(limit),
		.enabled_o(enabled)
	);

	// Time base; counting plain input clocks keeps durations tied to clock rate
	tick_prescaler #(
		.DIV(TICK_CYCLES)
	) u_prescale (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.restart_i(restart),
		.tick_o(tick)
	);

	// Restart sources: a new code, a command, or FIFO traffic in byte mode
	assign restart = enabled &&
		(s_r.start || (s_r.byte_mode && fifo_byte_i));
	assign last_tick = tick && (s_r.ticks == limit - TW'(1));

	// Next state of everything
	always_comb begin
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		events = '0;

		// Register writes
		if (wr_i) begin
			unique case (addr_i)
				byte_timer_pkg::ADDR_DUR_LOW: begin
					// Shared offset: other nibbles belong to other registers
					if (wdata_i[7:4] == byte_timer_pkg::LOW_SELECT) begin
						s_nxt.code_low = wdata_i[3:0];
						s_nxt.start = 1'b1;
					end
				end
				byte_timer_pkg::ADDR_DUR_HIGH: begin
					s_nxt.code_high = wdata_i[1:0];
					s_nxt.start = 1'b1;
				end
				byte_timer_pkg::ADDR_CTRL: begin
					s_nxt.byte_mode = wdata_i[byte_timer_pkg::CTRL_BYTE_MODE];
					s_nxt.periodic = wdata_i[byte_timer_pkg::CTRL_PERIODIC];
					if (wdata_i[byte_timer_pkg::CTRL_RESTART]) begin
						s_nxt.start = 1'b1;
					end
				end
				byte_timer_pkg::ADDR_MASK: begin
					s_nxt.mask = wdata_i[SW-1:0];
				end
				default: begin
				end
			endcase
		end

		// Timer sequencing; a disabled code parks it idle
		if (!enabled) begin
			s_nxt.state = byte_timer_pkg::ST_IDLE;
			s_nxt.ticks = '0;
		end else if (restart) begin
			s_nxt.state = byte_timer_pkg::ST_RUN;
			s_nxt.ticks = '0;
		end else begin
			unique case (s_r.state)
				byte_timer_pkg::ST_IDLE: begin
					s_nxt.state = byte_timer_pkg::ST_IDLE;
				end
				byte_timer_pkg::ST_RUN: begin
					if (last_tick) begin
						events[byte_timer_pkg::STAT_TIMEOUT] = 1'b1;
						if (s_r.status[byte_timer_pkg::STAT_TIMEOUT]) begin
							events[byte_timer_pkg::STAT_OVERRUN] = 1'b1;
						end
						s_nxt.ticks = '0;
						// Periodic mode rearms without software help
						s_nxt.state = s_r.periodic ? byte_timer_pkg::ST_RUN
							: byte_timer_pkg::ST_DONE;
					end else if (tick) begin
						s_nxt.ticks = s_r.ticks + TW'(1);
					end
				end
				byte_timer_pkg::ST_DONE: begin
					s_nxt.state = byte_timer_pkg::ST_DONE;
				end
				default: begin
					s_nxt.state = byte_timer_pkg::ST_IDLE;
				end
			endcase
		end

		// Count expiries, saturating so software sees it lost track
		if (events[byte_timer_pkg::STAT_TIMEOUT] && s_r.expiries != 8'hFF) begin
			s_nxt.expiries = s_r.expiries + 8'h01;
		end

		// Read data stand for one cycle only; status and expiry-count reads clear sticky state
		s_nxt.rdata = 8'h00;
		if (rd_i) begin
			if (addr_i == byte_timer_pkg::ADDR_CTRL) begin
				s_nxt.rdata[byte_timer_pkg::CTRL_BYTE_MODE] = s_r.byte_mode;
				s_nxt.rdata[byte_timer_pkg::CTRL_PERIODIC] = s_r.periodic;
			end else if (addr_i == byte_timer_pkg::ADDR_STATUS) begin
				s_nxt.rdata[SW-1:0] = s_r.status;
				s_nxt.status = '0;
			end else if (addr_i == byte_timer_pkg::ADDR_MASK) begin
				s_nxt.rdata[SW-1:0] = s_r.mask;
			end else if (addr_i == byte_timer_pkg::ADDR_STATE) begin
				s_nxt.rdata = {1'b0, s_r.state == byte_timer_pkg::ST_RUN,
					s_r.code_high, s_r.code_low};
			end else if (addr_i == byte_timer_pkg::ADDR_ELAPSED0) begin
				// Low byte read freezes the rest so the value stays coherent
				s_nxt.rdata = s_r.ticks[7:0];
				s_nxt.snap = s_r.ticks;
			end else if (addr_i > byte_timer_pkg::ADDR_ELAPSED0 &&
				addr_i < byte_timer_pkg::ADDR_EXPIRY_CNT) begin
				s_nxt.rdata = snap_byte(s_r.snap, addr_i - byte_timer_pkg::ADDR_ELAPSED0);
			end else if (addr_i == byte_timer_pkg::ADDR_EXPIRY_CNT) begin
				s_nxt.rdata = s_r.expiries;
				s_nxt.expiries = events[byte_timer_pkg::STAT_TIMEOUT] ? 8'h01 : 8'h00;
			end
		end

		// New events win over a clearing read in the same cycle
		s_nxt.status = s_nxt.status | events;

		// Level interrupt from unmasked sticky bits
		s_nxt.irq = |(s_nxt.status & s_nxt.mask);
		s_nxt.running = (s_nxt.state == byte_timer_pkg::ST_RUN);
	end

	// One register stage holds the whole record; low ce_i freezes it
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_r <= RESET_VAL;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign rdata_o = s_r.rdata;
	assign irq_o = s_r.irq;
	assign running_o = s_r.running;

endmodule : byte_timeout_timer

//--- hw/byte_timer_pkg.sv
// Constants for the instrument-bus timeout timer: offsets, fields, reset values, table.
// Assumes an 8-bit register port and a clock near the 40 MHz reference rate.
package byte_timer_pkg;

	// Register offsets on the plain register port
	localparam logic [7:0] ADDR_DUR_LOW = 8'h0A;
	localparam logic [7:0] ADDR_DUR_HIGH = 8'h0F;
	localparam logic [7:0] ADDR_CTRL = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h21;
	localparam logic [7:0] ADDR_MASK = 8'h22;
	localparam logic [7:0] ADDR_STATE = 8'h23;
	localparam logic [7:0] ADDR_ELAPSED0 = 8'h24;
	localparam logic [7:0] ADDR_EXPIRY_CNT = 8'h29;
	localparam int unsigned ELAPSED_BYTES = 5;

	// Shared auxiliary offset: only this upper nibble selects the low code part
	localparam logic [3:0] LOW_SELECT = 4'hF;
	localparam logic [7:0] DUR_LOW_RESET = 8'hF0;
	localparam logic [7:0] DUR_HIGH_RESET = 8'h00;

	// Control fields
	localparam int unsigned CTRL_BYTE_MODE = 0;
	localparam int unsigned CTRL_RESTART = 1;
	localparam int unsigned CTRL_PERIODIC = 2;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Status and mask fields
	localparam int unsigned STAT_W = 2;
	localparam int unsigned STAT_TIMEOUT = 0;
	localparam int unsigned STAT_OVERRUN = 1;
	localparam logic [1:0] STAT_RESET = 2'h0;
	localparam logic [1:0] MASK_RESET = 2'h0;

	// Duration code and tick counter
	localparam int unsigned CODE_W = 6;
	localparam int unsigned TICK_W = 34;
	localparam int unsigned REF_CLK_MHZ = 40;
	localparam int unsigned TICK_CYCLES = 5;
	localparam logic [5:0] CODE_OFF = 6'h00;
	localparam logic [5:0] CODE_300S = 6'h11;
	localparam logic [5:0] CODE_1000S = 6'h21;
	localparam longint unsigned TIME_300S_S = 300;
	localparam longint unsigned TIME_1000S_S = 1000;
	localparam longint unsigned TICKS_300S = TIME_300S_S * REF_CLK_MHZ * 1000000 / TICK_CYCLES;
	localparam longint unsigned TICKS_1000S = TIME_1000S_S * REF_CLK_MHZ * 1000000 / TICK_CYCLES;
	// Codes 1..15: timeout is 2**exp ticks of TICK_CYCLES clocks
	localparam int unsigned TICK_EXP [16] = '{0, 7, 8, 10, 11, 13, 15, 17, 18, 20,
		21, 23, 25, 27, 28, 30};

	// Timer sequencing
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_DONE = 3'b100
	} timer_state_t;

endpackage : byte_timer_pkg

//--- hw/duration_decode.sv
// Maps the six-bit duration code to a tick limit; pure combinational lookup.
// Assumes ticks of TICK_CYCLES input clocks; SHIFT shortens power-of-two entries.
`timescale 1ns/1ps
module duration_decode #(
	parameter int unsigned SHIFT = 0,
	parameter longint unsigned TICKS_300 = byte_timer_pkg::TICKS_300S,
	parameter longint unsigned TICKS_1000 = byte_timer_pkg::TICKS_1000S
) (
	input wire logic [byte_timer_pkg::CODE_W-1:0] code_i,
	output logic [byte_timer_pkg::TICK_W-1:0] limit_o,
	output logic enabled_o
);
	localparam int unsigned TW = byte_timer_pkg::TICK_W;

	if (TICKS_300 < 1 || TICKS_1000 < 1 || TICKS_1000 >= (64'h1 << TW)) begin : g_chk
		$error("duration_decode: long timeout ticks out of range");
	end

	// Zero and unlisted codes leave the timer disabled
	always_comb begin
		int unsigned e;
		e = byte_timer_pkg::TICK_EXP[code_i[3:0]];
		limit_o = '0;
		enabled_o = 1'b0;
		if (code_i[5:4] == 2'h0 && code_i[3:0] != 4'h0) begin
			limit_o = TW'(1) << ((e > SHIFT) ? (e - SHIFT) : 0);
			enabled_o = 1'b1;
		end else if (code_i == byte_timer_pkg::CODE_300S) begin
			limit_o = TW'(TICKS_300);
			enabled_o = 1'b1;
		end else if (code_i == byte_timer_pkg::CODE_1000S) begin
			limit_o = TW'(TICKS_1000);
			enabled_o = 1'b1;
		end
	end

endmodule : duration_decode

//--- hw/tick_prescaler.sv
// Divides the input clock into one-cycle ticks; restartable so a new period starts clean.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module tick_prescaler #(
	parameter int unsigned DIV = byte_timer_pkg::TICK_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic restart_i,
	output logic tick_o
);
	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
	} pre_state_t;

	pre_state_t s_r;
	pre_state_t s_nxt;

	if (DIV < 1) begin : g_chk
		$error("tick_prescaler: DIV must be at least one");
	end

	// Tick on the last count; a restart suppresses it and starts over
	assign tick_o = (s_r.cnt == LAST) && !restart_i;

	// Wraps at DIV so each tick stands DIV cycles apart
	always_comb begin
		s_nxt = s_r;
		if (restart_i || s_r.cnt == LAST) begin
			s_nxt.cnt = '0;
		end else begin
			s_nxt.cnt = s_r.cnt + CW'(1);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

endmodule : tick_prescaler

//--- tb/byte_timeout_timer_test.sv
// Self-checking bench for the timeout timer: register calls and expiry timing.
// Assumes shortened counts: one clock per tick, code 1 gives two ticks.
`timescale 1ns/1ps
module byte_timeout_timer_test;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic fifo_byte_i = 1'b0;
	logic [7:0] rdata_o;
	logic irq_o;
	logic running_o;
	int failures = 0;
	int total_checks = 0;
	int base;
	int n;
	logic [5:0] codes [5] = '{6'h01, 6'h02, 6'h03, 6'h11, 6'h21};
	int lims [5] = '{2, 4, 16, 10, 20};

	byte_timeout_timer #(.TICK_CYCLES(1), .TICK_SHIFT(6), .TICKS_300(10), .TICKS_1000(20))
		u_byte_timeout_timer (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .fifo_byte_i(fifo_byte_i),
		.rdata_o(rdata_o), .irq_o(irq_o), .running_o(running_o));

	// 100 MHz clock
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One-cycle strobes; a cycle gap between calls keeps each signal single-driven
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 check(rdata_o, exp);
	endtask : rd

	// Bounded wait; a hang ends the run through the closing report
	task automatic wait_irq(output int cyc);
		cyc = 0;
		while (irq_o !== 1'b1) begin
			@(posedge mclk_i);
			#1 cyc++;
			if (cyc > 200) begin
				failures++;
				$display("CHECK FAILED at %0t irq %h expected %h", $time, irq_o, 1'b1);
				summarize();
			end
		end
	endtask : wait_irq

	initial begin
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		// Reset values; write-only and unmapped places read zero
		rd(byte_timer_pkg::ADDR_STATE, 8'h00);
		rd(byte_timer_pkg::ADDR_DUR_LOW, 8'h00);
		rd(byte_timer_pkg::ADDR_DUR_HIGH, 8'h00);
		rd(8'h30, 8'h00);
		rd(byte_timer_pkg::ADDR_MASK, 8'h00);
		$display("reset test done");
		// Reserved low write ignored; both parts form the code
		wr(byte_timer_pkg::ADDR_DUR_LOW, 8'hE3);
		rd(byte_timer_pkg::ADDR_STATE, 8'h00);
		wr(byte_timer_pkg::ADDR_DUR_LOW, 8'hF3);
		repeat (2) @(posedge mclk_i);
		#1 check({7'h00, running_o}, 8'h01);
		rd(byte_timer_pkg::ADDR_STATE, 8'h43);
		wr(byte_timer_pkg::ADDR_DUR_HIGH, 8'h01);
		repeat (4) @(posedge mclk_i);
		#1 check({7'h00, running_o}, 8'h00);
		rd(byte_timer_pkg::ADDR_STATE, 8'h13);
		rd(byte_timer_pkg::ADDR_STATUS, 8'h00);
		$display("code test done");
		// Expiry delay grows with the code by exactly the limit difference
		wr(byte_timer_pkg::ADDR_MASK, 8'h01);
		for (int i = 0; i < 5; i++) begin
			wr(byte_timer_pkg::ADDR_DUR_HIGH, {6'h00, codes[i][5:4]});
			wr(byte_timer_pkg::ADDR_DUR_LOW, {4'hF, codes[i][3:0]});
			wait_irq(n);
			if (i == 0)
				base = n;
			check(8'(n - base), 8'(lims[i] - 2));
			rd(byte_timer_pkg::ADDR_STATUS, 8'h01);
			rd(byte_timer_pkg::ADDR_STATUS, 8'h00);
			check({7'h00, irq_o}, 8'h00);
		end
		// Masked expiry still sets status but keeps the line low
		wr(byte_timer_pkg::ADDR_MASK, 8'h00);
		wr(byte_timer_pkg::ADDR_DUR_HIGH, 8'h00);
		wr(byte_timer_pkg::ADDR_DUR_LOW, 8'hF1);
		repeat (8) @(posedge mclk_i);
		#1 check({7'h00, irq_o}, 8'h00);
		rd(byte_timer_pkg::ADDR_STATUS, 8'h01);
		$display("expiry test done");
		// Byte mode: FIFO bytes every 11 cycles hold off a 16-cycle timeout
		wr(byte_timer_pkg::ADDR_MASK, 8'h01);
		wr(byte_timer_pkg::ADDR_CTRL, 8'h01);
		wr(byte_timer_pkg::ADDR_DUR_LOW, 8'hF3);
		for (int i = 0; i < 6; i++) begin
			repeat (10) @(posedge mclk_i);
			fifo_byte_i <= 1'b1;
			@(posedge mclk_i);
			fifo_byte_i <= 1'b0;
		end
		#1 check({7'h00, irq_o}, 8'h00);
		wait_irq(n);
		check({7'h00, n > 11 && n < 20}, 8'h01);
		rd(byte_timer_pkg::ADDR_STATUS, 8'h01);
		wr(byte_timer_pkg::ADDR_CTRL, 8'h00);
		$display("byte mode test done");
		// Clock enable low stalls the count: delay in enabled clocks is unchanged
		wr(byte_timer_pkg::ADDR_DUR_LOW, 8'hF1);
		ce_i <= 1'b0;
		repeat (20) @(posedge mclk_i);
		ce_i <= 1'b1;
		#1 check({7'h00, irq_o}, 8'h00);
		wait_irq(n);
		check(8'(n), 8'(base));
		rd(byte_timer_pkg::ADDR_STATUS, 8'h01);
		$display("clock scaling test done");
		// Elapsed snapshot mid-run, then periodic rearm with overrun and expiry count
		wr(byte_timer_pkg::ADDR_DUR_LOW, 8'hF3);
		repeat (3) @(posedge mclk_i);
		rd(byte_timer_pkg::ADDR_ELAPSED0, 8'h03);
		rd(byte_timer_pkg::ADDR_ELAPSED0 + 8'h01, 8'h00);
		wait_irq(n);
		rd(byte_timer_pkg::ADDR_STATUS, 8'h01);
		wr(byte_timer_pkg::ADDR_DUR_LOW, 8'hF1);
		wr(byte_timer_pkg::ADDR_CTRL, 8'h06);
		rd(byte_timer_pkg::ADDR_CTRL, 8'h04);
		repeat (4) @(posedge mclk_i);
		wr(byte_timer_pkg::ADDR_CTRL, 8'h00);
		rd(byte_timer_pkg::ADDR_STATUS, 8'h03);
		rd(byte_timer_pkg::ADDR_STATUS, 8'h00);
		rd(byte_timer_pkg::ADDR_EXPIRY_CNT, 8'h0D);
		rd(byte_timer_pkg::ADDR_EXPIRY_CNT, 8'h00);
		$display("periodic test done");
		summarize();
	end
endmodule : byte_timeout_timer_test

//--- tb/byte_timer_chk.sv
// Port checks for the timeout timer: read data, code readback, start, expiry, freeze.
// Assumes one clock, synchronous active-high reset, strobes never both at once.
`timescale 1ns/1ps
module byte_timer_chk (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic fifo_byte_i,
	input wire logic [7:0] rdata_o,
	input wire logic irq_o,
	input wire logic running_o
);
	logic [3:0] lo_r;
	logic [1:0] hi_r;
	logic [1:0] mask_r;
	logic [5:0] code;
	logic en_c;
	// Shadow of accepted writes; reserved low writes must leave it alone
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			lo_r <= 4'h0;
			hi_r <= 2'h0;
			mask_r <= 2'h0;
		end else if (wr_i && ce_i) begin
			if (addr_i == byte_timer_pkg::ADDR_DUR_LOW && wdata_i[7:4] == 4'hF)
				lo_r <= wdata_i[3:0];
			if (addr_i == byte_timer_pkg::ADDR_DUR_HIGH)
				hi_r <= wdata_i[1:0];
			if (addr_i == byte_timer_pkg::ADDR_MASK)
				mask_r <= wdata_i[1:0];
		end
	end
	// Only low codes and the two single-upper-bit codes run
	assign code = {hi_r, lo_r};
	assign en_c = (code != 6'h00 && code[5:4] == 2'h0) || code == 6'h11 || code == 6'h21;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_low_write;
		wr_i && ce_i && addr_i == byte_timer_pkg::ADDR_DUR_LOW && wdata_i[7:4] == 4'hF;
	endsequence
	sequence s_settle;
		en_c && ce_i && !wr_i ##1 ce_i;
	endsequence
	chk_start_runs: assert property (s_low_write ##1 s_settle |-> ##[0:1] running_o)
		else $error("timer idle after start");
	chk_code_readback: assert property (rd_i && ce_i && addr_i == byte_timer_pkg::ADDR_STATE
		|=> rdata_o[5:0] == {$past(hi_r), $past(lo_r)}) else $error("code readback wrong");
	chk_wo_zero: assert property (rd_i && ce_i && (addr_i == 8'h0A || addr_i == 8'h0F
		|| addr_i == 8'h30) |=> rdata_o == 8'h00) else $error("write-only read not zero");
	chk_rdata_quiet: assert property (ce_i && !rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read slot");
	chk_disabled_idle: assert property ((!en_c && ce_i) [*4] |-> !running_o)
		else $error("disabled code runs");
	chk_freeze_all: assert property (!ce_i |=> $stable(running_o) && $stable(irq_o))
		else $error("state moved with clock enable low");
	chk_expiry_irq: assert property ($fell(running_o) && en_c && mask_r[0] && $past(ce_i)
		|-> ##[0:1] irq_o) else $error("expiry without interrupt");
	chk_mask_quiet: assert property ((mask_r == 2'h0) [*2] |-> !irq_o)
		else $error("masked interrupt raised");
endmodule : byte_timer_chk

bind byte_timeout_timer byte_timer_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .fifo_byte_i(fifo_byte_i),
	.rdata_o(rdata_o), .irq_o(irq_o), .running_o(running_o));
